//--- core/rfat_pkg.sv
package rfat_pkg;

    // Register port geometry
    localparam int DW = 32;
    localparam int AW = 3;

    // Register indices
    localparam logic [2:0] IDX_MODE = 3'h0;
    localparam logic [2:0] IDX_EVT = 3'h1;
    localparam logic [2:0] IDX_CAP = 3'h2;
    localparam logic [2:0] IDX_WEVT = 3'h3;
    localparam logic [2:0] IDX_SCR = 3'h4;

    // Field geometry
    localparam int FW = 8;
    localparam int CTRL_LSB = 0;
    localparam int STAT_LSB = 8;
    localparam int WO_LSB = 16;
    localparam int WRZ_LSB = 24;
    localparam int W1C_LSB = 0;
    localparam int ZCLR_LSB = 8;
    localparam int ACLR_LSB = 16;
    localparam int READ_ZERO_LSB = 24;
    localparam int READ_ZERO_W = 4;
    localparam int IGNORED_LSB = 28;
    localparam int IGNORED_W = 4;
    localparam int RC_W = 16;

    // Values after reset
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [7:0] WO_RST = 8'h00;
    localparam logic [7:0] WRZ_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] CLR_RST = 8'h00;
    localparam logic [15:0] RC_RST = 16'h0000;

    // Clear-on-write flavours
    typedef enum {
        CLR_ONE,
        CLR_ZERO,
        CLR_ANY
    } rfat_clr_e;

endpackage

//--- core/rfat_clr_bits.sv
`timescale 1ns/1ps
module rfat_clr_bits #(
    parameter rfat_pkg::rfat_clr_e MODE = rfat_pkg::CLR_ONE
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clr_wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] hw_set,
    output logic [7:0] bits_q
);

    logic [7:0] clr_mask;
    logic [7:0] bits_d;

    // Clear mask per flavour
    always_comb begin
        case (MODE)
            rfat_pkg::CLR_ONE: clr_mask = wdata;
            rfat_pkg::CLR_ZERO: clr_mask = ~wdata;
            rfat_pkg::CLR_ANY: clr_mask = 8'hFF;
            default: clr_mask = 8'h00;
        endcase
        if (!clr_wr) begin
            clr_mask = 8'h00;
        end
        bits_d = (bits_q & ~clr_mask) | hw_set;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            bits_q <= rfat_pkg::CLR_RST;
        end else begin
            bits_q <= bits_d;
        end
    end

endmodule

//--- core/rfat_rc_field.sv
`timescale 1ns/1ps
module rfat_rc_field (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sw_read,
    input wire logic hw_load,
    input wire logic [15:0] hw_data,
    output logic hw_ready,
    output logic full_q,
    output logic [15:0] val_q
);

    // Load accepted when empty or while being read
    assign hw_ready = !full_q || sw_read;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            full_q <= 1'b0;
        end else if (hw_load && hw_ready) begin
            full_q <= 1'b1;
        end else if (sw_read) begin
            full_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            val_q <= rfat_pkg::RC_RST;
        end else if (hw_load && hw_ready) begin
            val_q <= hw_data;
        end else if (sw_read) begin
            val_q <= rfat_pkg::RC_RST;
        end
    end

endmodule

//--- core/rfat_bank.sv
// Operation
// - Read-write field returns stored value and takes written value.
// - Read-only field follows hardware; software writes leave it unchanged.
// - Write-only field passes written value to hardware; read value undefined.
// - Write-reads-zero field drives hardware; every software read returns zero.
// - Write-one-to-clear: a one clears the bit, a zero leaves it.
// - Write-zero-to-clear: a zero clears the bit, a one leaves it.
// - Write-any-clears bit cleared by any write to its register.
// - Clear bits readable unless register is write-only, then undefined.
// - Read-to-clear field holds hardware value until read; then reloadable.
// - Reads-as-zero bits always return zero on read.
// - Ignored bits have no write effect; read value undefined.
// - Fields with initial value are loaded at reset; others unset.
`timescale 1ns/1ps
module rfat_bank (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sw_wr,
    input wire logic sw_rd,
    input wire logic [2:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    output logic [31:0] sw_rdata,
    output logic sw_rvalid,
    input wire logic [7:0] hw_status,
    output logic [7:0] ctrl_out,
    output logic [7:0] wo_out,
    output logic [7:0] write_reads_zero_out,
    input wire logic [7:0] hw_w1c_set,
    input wire logic [7:0] hw_write_zero_clears_set,
    input wire logic [7:0] hw_write_any_clears_set,
    input wire logic [7:0] hw_wevt_set,
    output logic [7:0] w1c_bits,
    output logic [7:0] write_zero_clears_bits,
    output logic [7:0] write_any_clears_bits,
    output logic [7:0] wevt_bits,
    input wire logic hw_rc_load,
    input wire logic [15:0] hw_rc_data,
    output logic hw_rc_ready,
    output logic rc_full,
    output logic [31:0] scratch_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic logic hit(input logic [2:0] addr, input logic [2:0] idx);
        hit = (addr == idx);
    endfunction

    logic wr_mode;
    logic wr_evt;
    logic wr_wevt;
    logic wr_scr;
    logic rd_cap;

    assign wr_mode = sw_wr && hit(sw_addr, rfat_pkg::IDX_MODE);
    assign wr_evt = sw_wr && hit(sw_addr, rfat_pkg::IDX_EVT);
    assign wr_wevt = sw_wr && hit(sw_addr, rfat_pkg::IDX_WEVT);
    assign wr_scr = sw_wr && hit(sw_addr, rfat_pkg::IDX_SCR);
    assign rd_cap = sw_rd && hit(sw_addr, rfat_pkg::IDX_CAP);

    ////////////////////////////////////////////////////////////////////////////
    // Mixed field register

    logic [7:0] ctrl_q;
    logic [7:0] stat_q;
    logic [7:0] wo_q;
    logic [7:0] wrz_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_q <= rfat_pkg::CTRL_RST;
        end else if (wr_mode) begin
            ctrl_q <= sw_wdata[rfat_pkg::CTRL_LSB +: rfat_pkg::FW];
        end
    end

    // Hardware owned; no software write path exists
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            stat_q <= rfat_pkg::STAT_RST;
        end else begin
            stat_q <= hw_status;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wo_q <= rfat_pkg::WO_RST;
        end else if (wr_mode) begin
            wo_q <= sw_wdata[rfat_pkg::WO_LSB +: rfat_pkg::FW];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wrz_q <= rfat_pkg::WRZ_RST;
        end else if (wr_mode) begin
            wrz_q <= sw_wdata[rfat_pkg::WRZ_LSB +: rfat_pkg::FW];
        end
    end

    assign ctrl_out = ctrl_q;
    assign wo_out = wo_q;
    assign write_reads_zero_out = wrz_q;

    ////////////////////////////////////////////////////////////////////////////
    // Clear-on-write bits

    rfat_clr_bits #(.MODE(rfat_pkg::CLR_ONE)) u_w1c (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clr_wr(wr_evt),
        .wdata(sw_wdata[rfat_pkg::W1C_LSB +: rfat_pkg::FW]),
        .hw_set(hw_w1c_set),
        .bits_q(w1c_bits)
    );

    rfat_clr_bits #(.MODE(rfat_pkg::CLR_ZERO)) u_zero_clr (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clr_wr(wr_evt),
        .wdata(sw_wdata[rfat_pkg::ZCLR_LSB +: rfat_pkg::FW]),
        .hw_set(hw_write_zero_clears_set),
        .bits_q(write_zero_clears_bits)
    );

    rfat_clr_bits #(.MODE(rfat_pkg::CLR_ANY)) u_any_clr (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clr_wr(wr_evt),
        .wdata(sw_wdata[rfat_pkg::ACLR_LSB +: rfat_pkg::FW]),
        .hw_set(hw_write_any_clears_set),
        .bits_q(write_any_clears_bits)
    );

    // Write-only register of write-one-to-clear bits
    rfat_clr_bits #(.MODE(rfat_pkg::CLR_ONE)) u_wevt (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clr_wr(wr_wevt),
        .wdata(sw_wdata[rfat_pkg::W1C_LSB +: rfat_pkg::FW]),
        .hw_set(hw_wevt_set),
        .bits_q(wevt_bits)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read-to-clear capture

    logic [15:0] rc_val;

    rfat_rc_field u_rc (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .sw_read(rd_cap),
        .hw_load(hw_rc_load),
        .hw_data(hw_rc_data),
        .hw_ready(hw_rc_ready),
        .full_q(rc_full),
        .val_q(rc_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Scratch word, no initial value

    logic [31:0] scr_q;

    always_ff @(posedge ref_clk) begin
        if (wr_scr) begin
            scr_q <= sw_wdata;
        end
    end

    assign scratch_out = scr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic [2:0] rd_idx_q;

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (sw_addr)
            rfat_pkg::IDX_MODE: begin
                rdata_d[rfat_pkg::CTRL_LSB +: rfat_pkg::FW] = ctrl_q;
                rdata_d[rfat_pkg::STAT_LSB +: rfat_pkg::FW] = stat_q;
                // Write-only and write-reads-zero fields stay zero
            end
            rfat_pkg::IDX_EVT: begin
                rdata_d[rfat_pkg::W1C_LSB +: rfat_pkg::FW] = w1c_bits;
                rdata_d[rfat_pkg::ZCLR_LSB +: rfat_pkg::FW] = write_zero_clears_bits;
                rdata_d[rfat_pkg::ACLR_LSB +: rfat_pkg::FW] = write_any_clears_bits;
                // Upper bits read zero and hold no state
            end
            rfat_pkg::IDX_CAP: begin
                rdata_d[rfat_pkg::RC_W-1:0] = rc_val;
            end
            rfat_pkg::IDX_WEVT: begin
                rdata_d = 32'h0000_0000;
            end
            rfat_pkg::IDX_SCR: begin
                rdata_d = scr_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (sw_rd) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rd_idx_q <= 3'h0;
        end else begin
            rvalid_q <= sw_rd;
            rd_idx_q <= sw_addr;
        end
    end

    assign sw_rdata = rdata_q;
    assign sw_rvalid = rvalid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_rw_takes_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_mode |=> ctrl_out == $past(sw_wdata[7:0]))
        else $error("read-write field did not take write");

    a_ro_follows_hw: assert property (@(posedge ref_clk) disable iff (!rstn)
        sw_rvalid && rd_idx_q == rfat_pkg::IDX_MODE && $past(wr_mode) && $past(rstn, 2)
        |-> sw_rdata[15:8] == $past(hw_status, 2))
        else $error("read-only field changed by write");

    a_wo_passes_value: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_mode ##1 !wr_mode |-> wo_out == $past(sw_wdata[23:16]))
        else $error("write-only field lost value");

    a_wrz_reads_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        sw_rvalid && rd_idx_q == rfat_pkg::IDX_MODE |-> sw_rdata[31:16] == 16'h0000)
        else $error("write-reads-zero field read nonzero");

    a_w1c_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_evt |=> w1c_bits == (($past(w1c_bits) & ~$past(sw_wdata[7:0]))
            | $past(hw_w1c_set)))
        else $error("write-one-to-clear wrong");

    a_zero_clr_bits: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_evt |=> write_zero_clears_bits == (($past(write_zero_clears_bits)
            & $past(sw_wdata[15:8])) | $past(hw_write_zero_clears_set)))
        else $error("write-zero-to-clear wrong");

    a_any_clr_bits: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_evt |=> write_any_clears_bits == $past(hw_write_any_clears_set))
        else $error("write-any-clears bit not cleared");

    a_wevt_reads_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        sw_rvalid && rd_idx_q == rfat_pkg::IDX_WEVT |-> sw_rdata == 32'h0000_0000)
        else $error("write-only register read nonzero");

    a_rc_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
        rc_full && !rd_cap |=> rc_full && $stable(rc_val))
        else $error("read-to-clear value changed before read");

    a_unused_reads_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        sw_rvalid && rd_idx_q == rfat_pkg::IDX_EVT |-> sw_rdata[31:24] == 8'h00)
        else $error("reads-as-zero bits nonzero");

    a_hw_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_evt && (hw_w1c_set != 8'h00) |=> (w1c_bits & $past(hw_w1c_set))
            == $past(hw_w1c_set))
        else $error("hardware set lost to clear");

    a_reset_init: assert property (@(posedge ref_clk)
        $past(!rstn) && rstn |-> ctrl_out == rfat_pkg::CTRL_RST && w1c_bits == 8'h00)
        else $error("initial value not loaded");

    a_rvalid_follows_rd: assert property (@(posedge ref_clk) disable iff (!rstn)
        sw_rd |=> sw_rvalid)
        else $error("read answer missing");

    a_rc_read_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd_cap && !hw_rc_load |=> !rc_full)
        else $error("read-to-clear field not emptied");

    a_rw_holds_value: assert property (@(posedge ref_clk) disable iff (!rstn)
        !wr_mode |=> $stable(ctrl_out))
        else $error("read-write field changed without write");

endmodule

//--- tb/tb_rfat_bank.sv
`timescale 1ns/1ps
module tb_rfat_bank;
logic ref_clk;
logic rstn;
logic sw_wr;
logic sw_rd;
logic [2:0] sw_addr;
logic [31:0] sw_wdata;
logic [31:0] sw_rdata;
logic [31:0] scratch_out;
logic sw_rvalid;
logic [7:0] hw_status, ctrl_out, wo_out, write_reads_zero_out;
logic [7:0] hw_w1c_set, hw_write_zero_clears_set, hw_write_any_clears_set, hw_wevt_set;
logic [7:0] w1c_bits, write_zero_clears_bits, write_any_clears_bits, wevt_bits;
logic hw_rc_load, hw_rc_ready, rc_full;
logic [15:0] hw_rc_data;
integer seed = 34528;
int num_errors = 0;
int checks = 0;
logic [7:0] m_ctrl, m_wo, m_wrz, m_stat, m_w1c, m_zclr, m_aclr, m_wset, m_wevt;
logic [15:0] m_val;
logic m_full, m_rvalid, m_scr_ok, m_rchk;
logic en_chk = 1'b0;
logic [31:0] m_scr, m_rdata;
logic evt_wr, cap_rd, wevt_wr;
assign evt_wr = sw_wr && sw_addr == rfat_pkg::IDX_EVT;
assign cap_rd = sw_rd && sw_addr == rfat_pkg::IDX_CAP;
assign wevt_wr = sw_wr && sw_addr == rfat_pkg::IDX_WEVT;

rfat_bank rfat_bank_inst (.ref_clk(ref_clk), .rstn(rstn), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_rdata(sw_rdata), .sw_rvalid(sw_rvalid),
    .hw_status(hw_status), .ctrl_out(ctrl_out), .wo_out(wo_out),
    .write_reads_zero_out(write_reads_zero_out), .hw_w1c_set(hw_w1c_set),
    .hw_write_zero_clears_set(hw_write_zero_clears_set),
    .hw_write_any_clears_set(hw_write_any_clears_set), .hw_wevt_set(hw_wevt_set),
    .w1c_bits(w1c_bits), .write_zero_clears_bits(write_zero_clears_bits),
    .write_any_clears_bits(write_any_clears_bits), .wevt_bits(wevt_bits),
    .hw_rc_load(hw_rc_load), .hw_rc_data(hw_rc_data), .hw_rc_ready(hw_rc_ready),
    .rc_full(rc_full), .scratch_out(scratch_out));

initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
end

////////////////////////////////////////////////////////////////////////////////
// Reference model
function automatic logic [31:0] rd_exp(input logic [2:0] a);
    case (a)
        rfat_pkg::IDX_MODE: return {16'h0000, m_stat, m_ctrl};
        rfat_pkg::IDX_EVT: return {8'h00, m_aclr, m_zclr, m_w1c};
        rfat_pkg::IDX_CAP: return {16'h0000, m_val};
        rfat_pkg::IDX_SCR: return m_scr;
        default: return 32'h00000000;
    endcase
endfunction

always @(posedge ref_clk) begin
    en_chk <= 1'b1;
    if (!rstn) begin
        {m_wo, m_wrz, m_stat, m_w1c, m_zclr, m_aclr, m_wset, m_wevt} <= 64'h0;
        m_ctrl <= rfat_pkg::CTRL_RST;
        {m_val, m_full, m_rvalid, m_scr_ok} <= 19'h0;
        m_rdata <= 32'h00000000;
        m_rchk <= 1'b1;
    end else begin
        m_stat <= hw_status;
        m_wset <= hw_wevt_set;
        m_w1c <= (m_w1c & ~(evt_wr ? sw_wdata[7:0] : 8'h00)) | hw_w1c_set;
        m_zclr <= (m_zclr & ~(evt_wr ? ~sw_wdata[15:8] : 8'h00)) | hw_write_zero_clears_set;
        m_aclr <= (m_aclr & ~{8{evt_wr}}) | hw_write_any_clears_set;
        m_wevt <= (m_wevt & ~(wevt_wr ? sw_wdata[7:0] : 8'h00)) | hw_wevt_set;
        m_rvalid <= sw_rd;
        if (sw_rd) begin
            m_rdata <= rd_exp(sw_addr);
            m_rchk <= !(sw_addr == rfat_pkg::IDX_SCR && !m_scr_ok);
        end
        if (hw_rc_load && (!m_full || cap_rd)) begin
            m_val <= hw_rc_data;
            m_full <= 1'b1;
        end else if (cap_rd) begin
            m_val <= 16'h0000;
            m_full <= 1'b0;
        end
        if (sw_wr && sw_addr == rfat_pkg::IDX_MODE) begin
            {m_wrz, m_wo, m_ctrl} <= {sw_wdata[31:16], sw_wdata[7:0]};
        end
        if (sw_wr && sw_addr == rfat_pkg::IDX_SCR) begin
            m_scr <= sw_wdata;
            m_scr_ok <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Checks
task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
        num_errors++;
        $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
endtask

always @(negedge ref_clk) begin
    if (en_chk === 1'b1) begin
        chk(32'(ctrl_out), 32'(m_ctrl), "ctrl");
        chk(32'(wo_out), 32'(m_wo), "wo");
        chk(32'(write_reads_zero_out), 32'(m_wrz), "wrz");
        chk(32'(w1c_bits), 32'(m_w1c), "w1c");
        chk(32'(write_zero_clears_bits), 32'(m_zclr), "zclr");
        chk(32'(write_any_clears_bits), 32'(m_aclr), "aclr");
        chk(32'(wevt_bits & m_wset), 32'(m_wset), "wevt set");
        chk(32'(wevt_bits), 32'(m_wevt), "wevt");
        chk(32'(rc_full), 32'(m_full), "full");
        chk(32'(hw_rc_ready), 32'(!m_full || cap_rd), "ready");
        chk(32'(sw_rvalid), 32'(m_rvalid), "rvalid");
        if (m_rchk) chk(sw_rdata, m_rdata, "rdata");
        if (m_scr_ok) chk(scratch_out, m_scr, "scratch");
    end
end

////////////////////////////////////////////////////////////////////////////////
// Stimulus
task automatic drive(input logic rnd, input logic wr, input logic rd, input logic [2:0] a,
    input logic [31:0] d);
    logic [31:0] r;
    logic [31:0] s;
    r = $random(seed);
    s = $random(seed);
    @(posedge ref_clk);
    sw_wr <= rnd ? r[0] : wr;
    sw_rd <= rnd ? r[1] : rd;
    sw_addr <= rnd ? r[4:2] : a;
    sw_wdata <= rnd ? s : d;
    hw_status <= r[15:8];
    hw_w1c_set <= rnd ? (s[7:0] & s[15:8] & r[23:16]) : 8'h00;
    hw_write_zero_clears_set <= rnd ? (s[15:8] & s[23:16] & r[31:24]) : 8'h00;
    hw_write_any_clears_set <= rnd ? (s[23:16] & s[31:24] & r[15:8]) : 8'h00;
    hw_wevt_set <= rnd ? (s[31:24] & r[23:16]) : 8'h00;
    hw_rc_load <= rnd & r[5];
    hw_rc_data <= s[15:0];
endtask

task automatic summarize;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask

initial begin
    rstn = 1'b0;
    {sw_wr, sw_rd, sw_addr, sw_wdata} = 37'h0;
    {hw_status, hw_w1c_set, hw_write_zero_clears_set} = 24'h0;
    {hw_write_any_clears_set, hw_wevt_set} = 16'h0;
    {hw_rc_load, hw_rc_data} = 17'h0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk(32'(ctrl_out), 32'(rfat_pkg::CTRL_RST), "reset ctrl");
    $display("test reset done");
    repeat (2000) drive(1'b1, 1'b0, 1'b0, 3'h0, 32'h0);
    $display("test random done");
    drive(1'b0, 1'b1, 1'b0, rfat_pkg::IDX_EVT, 32'hFFFFFFFF);
    drive(1'b0, 1'b1, 1'b1, rfat_pkg::IDX_EVT, 32'h00000000);
    drive(1'b0, 1'b0, 1'b1, rfat_pkg::IDX_EVT, 32'h00000000);
    drive(1'b0, 1'b1, 1'b1, rfat_pkg::IDX_EVT, 32'h00FF00FF);
    drive(1'b0, 1'b1, 1'b1, 3'h5, 32'hFFFFFFFF);
    drive(1'b0, 1'b1, 1'b1, rfat_pkg::IDX_WEVT, 32'hFFFFFFFF);
    drive(1'b0, 1'b0, 1'b1, rfat_pkg::IDX_CAP, 32'h00000000);
    drive(1'b0, 1'b0, 1'b1, rfat_pkg::IDX_CAP, 32'h00000000);
    drive(1'b0, 1'b0, 1'b0, 3'h0, 32'h0);
    $display("test corner done");
    rstn <= 1'b0;
    repeat (2) drive(1'b1, 1'b0, 1'b0, 3'h0, 32'h0);
    rstn <= 1'b1;
    repeat (500) drive(1'b1, 1'b0, 1'b0, 3'h0, 32'h0);
    $display("test second reset done");
    summarize();
end
endmodule
